/* hdl/mlx_access_guard.sv */
`timescale 1ns/1ps
module mlx_access_guard (
   // clock and synchronised reset
   input wire logic core_clk,
   input wire logic rst_n,
   // media access request
   input wire logic acc_req,
   input wire logic [47:0] acc_lba,
   input wire logic [47:0] limit,
   // verdict, one cycle after the request
   output logic acc_abort,
   output logic acc_ok
);
   import mlx_pkg::*;

   // registered verdict; the limit is inclusive, the highest address is usable
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_abort <= 1'b0;
         acc_ok <= 1'b0;
      end else begin
         acc_abort <= acc_req && (acc_lba > limit);
         acc_ok <= acc_req && (acc_lba <= limit);
      end
   end

   AST_BEYOND_LIMIT: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_req && (acc_lba > limit) |=> acc_abort && !acc_ok)
      else $error("access beyond limit not aborted");
endmodule // mlx_access_guard

/* hdl/mlx_max_lba_ext.sv */
`timescale 1ns/1ps
// How it works
// - command code 37h sets extended limit
// - accepted value replaces current highest address
// - accesses beyond limit are aborted
// - above 28-bit range: update words 103:100 only
// - within 28-bit range: update both word groups
// - abort unsupported, oversize, old area, no read
// - locked or frozen aborts, limit unchanged
// - one non-volatile change per power cycle
// - non-volatile limit survives power-on reset
// - non-volatile request invalid in offset mode
// - limit read back through hob pages
// - lock entered, left on unlock/freeze/power
// - freeze rejects all later set-max commands
module mlx_max_lba_ext (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // task file from the host
   input wire logic tf_wr,
   input wire mlx_pkg::mlx_tf_t tf,
   input wire logic hob,
   // task file answers
   output mlx_pkg::mlx_rb_t rb,
   output logic [7:0] status_flags,
   output logic [7:0] error_report,
   output logic cmd_done,
   // drive context
   input wire logic feature_on,
   input wire logic [47:0] native_cap,
   input wire logic hpa28_set,
   input wire logic offset_mode,
   // accepted set-max subcommands from the sibling handler
   input wire logic lock_acc,
   input wire logic unlock_acc,
   input wire logic freeze_acc,
   // persistent limit store
   input wire logic nv_valid_in,
   input wire logic [47:0] nv_limit_in,
   output logic nv_wr,
   output logic [47:0] nv_wr_lba,
   // identify words and current limit
   output logic [63:0] id_w100_103,
   output logic [31:0] id_w60_61,
   output logic [47:0] max_limit,
   // media access check
   input wire logic acc_req,
   input wire logic [47:0] acc_lba,
   output logic acc_abort,
   output logic acc_ok
);
   import mlx_pkg::*;

   typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_EXEC} mlx_state_t;

   logic rst_s1_q; // first sync stage, read only by the second
   logic rst_n; // synchronised reset used everywhere else
   mlx_state_t state_q;
   mlx_tf_t cmd_q; // command latched at acceptance
   logic [47:0] limit_q; // current highest addressable block
   logic [47:0] req_lba; // limit requested by the latched command
   logic [47:0] rb_src_q; // value the host reads back
   logic is_set; // latched command is the extended set
   logic want_nv; // non-volatile request
   logic abort; // set command must be refused
   logic accept; // set command takes effect this cycle
   logic after_native_q; // previous command was the native read
   logic locked_q;
   logic frozen_q;
   logic nv_used_q; // one non-volatile change already taken

   // reset release through two flops; assertion is still immediate
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // byte assembly of the requested limit
   assign req_lba = {cmd_q.ch_prev, cmd_q.cl_prev, cmd_q.sn_prev,
                     cmd_q.ch_cur, cmd_q.cl_cur, cmd_q.sn_cur};
   assign is_set = (cmd_q.cmd == MLX_CMD_SET_MAX_EXT);
   assign want_nv = cmd_q.sc_cur[MLX_SC_NV_BIT];

   // every refusal reason, checked before anything is changed
   always_comb begin
      abort = 1'b0;
      if (!feature_on || hpa28_set || !after_native_q) begin
         abort = 1'b1;
      end
      if (req_lba > native_cap) begin
         abort = 1'b1;
      end
      if (locked_q || frozen_q) begin
         abort = 1'b1;
      end
      if (want_nv && (offset_mode || nv_used_q)) begin
         abort = 1'b1;
      end
   end
   assign accept = (state_q == ST_EXEC) && is_set && !abort;

   // command sequencer: one busy cycle per command, writes while busy are dropped
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_INIT;
         cmd_q <= '0;
      end else begin
         case (state_q)
            ST_INIT: begin
               state_q <= ST_IDLE;
            end
            ST_IDLE: begin
               if (tf_wr) begin
                  cmd_q <= tf;
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // current limit; taken once after reset release from the store if valid, else native capacity
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         limit_q <= '0;
      end else if (state_q == ST_INIT) begin
         limit_q <= nv_valid_in ? nv_limit_in : native_cap;
      end else if (accept) begin
         limit_q <= req_lba;
      end
   end
   assign max_limit = limit_q;

   // identify words follow the limit, the 28-bit pair only when an accepted limit fits; reset loads 0, the first cycle after release loads the pair with 0fff_ffff
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         id_w100_103 <= '0;
         id_w60_61 <= '0;
      end else if (state_q == ST_INIT) begin
         id_w100_103 <= {16'h0000, nv_valid_in ? nv_limit_in : native_cap};
         id_w60_61 <= 32'h0fff_ffff;
      end else if (accept) begin
         id_w100_103 <= {16'h0000, req_lba};
         if (req_lba <= MLX_LBA28_MAX) begin
            id_w60_61 <= req_lba[31:0];
         end
      end
   end

   // non-volatile write to the store, one pulse per accepted request
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_wr <= 1'b0;
         nv_wr_lba <= '0;
         nv_used_q <= 1'b0;
      end else begin
         nv_wr <= accept && want_nv;
         if (accept && want_nv) begin
            nv_wr_lba <= req_lba;
            nv_used_q <= 1'b1;
         end
      end
   end

   // native-read record, renewed by every completed command
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         after_native_q <= 1'b0;
      end else if (state_q == ST_EXEC) begin
         after_native_q <= (cmd_q.cmd == MLX_CMD_READ_NATIVE_EXT);
      end
   end

   // lock and freeze; a lock arriving with an unlock wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         locked_q <= 1'b0;
         frozen_q <= 1'b0;
      end else begin
         if (lock_acc) begin
            locked_q <= 1'b1;
         end else if (unlock_acc || freeze_acc) begin
            locked_q <= 1'b0;
         end
         if (freeze_acc) begin
            frozen_q <= 1'b1;
         end
      end
   end

   // status, error and completion pulse
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_flags <= MLX_STATUS_RST;
         error_report <= MLX_ERROR_RST;
         cmd_done <= 1'b0;
      end else begin
         cmd_done <= (state_q == ST_EXEC);
         if (state_q == ST_INIT) begin
            status_flags <= MLX_STATUS_OK;
         end else if (state_q == ST_IDLE && tf_wr) begin
            status_flags <= MLX_STATUS_BUSY;
         end else if (state_q == ST_EXEC) begin
            if (is_set && abort) begin
               status_flags <= MLX_STATUS_FAIL;
               error_report <= MLX_ERROR_ABT;
            end else begin
               status_flags <= MLX_STATUS_OK;
               error_report <= MLX_ERROR_RST;
            end
         end
      end
   end

   // readback source: the new limit after an accepted set, the unchanged limit after a refused one, native capacity after a native read
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rb_src_q <= '0;
      end else if (accept) begin
         rb_src_q <= req_lba;
      end else if (state_q == ST_EXEC && is_set) begin
         rb_src_q <= limit_q;
      end else if (state_q == ST_EXEC && cmd_q.cmd == MLX_CMD_READ_NATIVE_EXT) begin
         rb_src_q <= native_cap;
      end
   end

   // hob page select, registered so the bytes come from flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rb <= '0;
      end else if (hob) begin
         rb <= '{sn: rb_src_q[31:24], cl: rb_src_q[39:32], ch: rb_src_q[47:40]};
      end else begin
         rb <= '{sn: rb_src_q[7:0], cl: rb_src_q[15:8], ch: rb_src_q[23:16]};
      end
   end

   // range check on media accesses
   mlx_access_guard u_guard (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .acc_req(acc_req),
      .acc_lba(acc_lba),
      .limit(limit_q),
      .acc_abort(acc_abort),
      .acc_ok(acc_ok)
   );

   AST_SET_TAKES: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept |=> (limit_q == $past(req_lba)) && status_flags[MLX_ST_RDY])
      else $error("accepted limit not applied");

   AST_LOCK_ABORT: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_EXEC) && is_set && (locked_q || frozen_q)
      |=> $stable(limit_q) && error_report[MLX_ER_ABT])
      else $error("set while locked or frozen not aborted");

   AST_NEEDS_NATIVE: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_EXEC) && is_set && !after_native_q |=> status_flags[MLX_ST_ERR])
      else $error("set without native read not aborted");

   AST_WORDS_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && (req_lba > MLX_LBA28_MAX)
      |=> $stable(id_w60_61) && (id_w100_103[47:0] == $past(req_lba)))
      else $error("identify words wrong for large limit");

   AST_WORDS_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && (req_lba <= MLX_LBA28_MAX)
      |=> (id_w60_61 == $past(req_lba[31:0])) && (id_w100_103[47:0] == $past(req_lba)))
      else $error("identify words wrong for small limit");

   AST_NV_ONCE: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_EXEC) && is_set && want_nv && nv_used_q |=> error_report[MLX_ER_ABT])
      else $error("second non-volatile set not aborted");

   AST_NV_OFFSET: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_EXEC) && is_set && want_nv && offset_mode |=> !nv_wr && $stable(limit_q))
      else $error("non-volatile set taken in offset mode");

   AST_NV_STORE: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && want_nv |=> nv_wr && (nv_wr_lba == $past(req_lba)))
      else $error("non-volatile limit not stored");

   AST_BUSY_THEN_READY: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_IDLE) && tf_wr |=> status_flags[MLX_ST_BSY] ##1
      (cmd_done && !status_flags[MLX_ST_BSY] && status_flags[MLX_ST_RDY]))
      else $error("busy and ready sequence broken");

   AST_NATIVE_FORGOT: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_q == ST_EXEC) && (cmd_q.cmd != MLX_CMD_READ_NATIVE_EXT) |=> !after_native_q)
      else $error("native read record not cleared");

   AST_LOCK_ENTER: assert property (@(posedge core_clk) disable iff (!rst_n)
      lock_acc |=> locked_q)
      else $error("lock not entered");

   AST_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n)
      freeze_acc && !lock_acc |=> frozen_q && !locked_q)
      else $error("freeze not entered");

   AST_HOB_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
      !hob |=> rb.sn == $past(rb_src_q[7:0]))
      else $error("low readback byte wrong");
endmodule // mlx_max_lba_ext

/* hdl/mlx_pkg.sv */
package mlx_pkg;
   // command codes seen on the task file
   localparam logic [7:0] MLX_CMD_SET_MAX_EXT = 8'h37;
   localparam logic [7:0] MLX_CMD_READ_NATIVE_EXT = 8'h27;
   // status register bit positions
   localparam int MLX_ST_BSY = 7;
   localparam int MLX_ST_RDY = 6;
   localparam int MLX_ST_ERR = 0;
   // error register bit position of the abort flag
   localparam int MLX_ER_ABT = 2;
   // persistence select bit in the current sector count byte
   localparam int MLX_SC_NV_BIT = 0;
   // largest limit that still fits the 28-bit identify words
   localparam logic [47:0] MLX_LBA28_MAX = 48'h0000_0fff_ffff;
   // register reset and response values
   localparam logic [7:0] MLX_STATUS_RST = 8'h80;
   localparam logic [7:0] MLX_ERROR_RST = 8'h00;
   localparam logic [7:0] MLX_STATUS_BUSY = 8'h80;
   localparam logic [7:0] MLX_STATUS_OK = 8'h40;
   localparam logic [7:0] MLX_STATUS_FAIL = 8'h41;
   localparam logic [7:0] MLX_ERROR_ABT = 8'h04;

   // one command as the host leaves it in the task file
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] sc_cur;
      logic [7:0] sc_prev;
      logic [7:0] sn_cur;
      logic [7:0] sn_prev;
      logic [7:0] cl_cur;
      logic [7:0] cl_prev;
      logic [7:0] ch_cur;
      logic [7:0] ch_prev;
   } mlx_tf_t;

   // address bytes returned to the host, page chosen by the hob select
   typedef struct packed {
      logic [7:0] sn;
      logic [7:0] cl;
      logic [7:0] ch;
   } mlx_rb_t;
endpackage

/* verification/mlx_host.sv */
`timescale 1ns/1ps
module mlx_host (
   // clock
   input wire logic core_clk,
   // task file toward the device
   output logic tf_wr,
   output mlx_pkg::mlx_tf_t tf
);
   import mlx_pkg::*;
   // idle task file after power-up
   initial begin
      tf_wr = 1'b0;
      tf = '0;
   end
   // one command in a single strobe cycle; bytes are scrambled afterwards so stale
   // values never pass for a held request
   task automatic send(input logic [7:0] c, input logic [47:0] l, input logic nv);
      @(posedge core_clk);
      tf_wr <= 1'b1;
      tf <= '{c, {7'h00, nv}, 8'h00, l[7:0], l[31:24], l[15:8], l[39:32], l[23:16], l[47:40]};
      @(posedge core_clk);
      tf_wr <= 1'b0;
      tf <= ~tf;
   endtask
endmodule // mlx_host

/* verification/tb_max_lba_limit_ext_command.sv */
`timescale 1ns/1ps
module tb_max_lba_limit_ext_command;
   import mlx_pkg::*;
   // above the 28-bit range, with every upper readback byte nonzero
   localparam logic [47:0] CAP = 48'h03a5_7000_0000;
   localparam logic [7:0] SET = MLX_CMD_SET_MAX_EXT;
   localparam logic [7:0] RDN = MLX_CMD_READ_NATIVE_EXT;
   logic core_clk = 1'b0, rst_b = 1'b0, hob = 1'b0, feature_on = 1'b1, hpa28_set = 1'b0;
   logic offset_mode = 1'b0, lock_acc = 1'b0, unlock_acc = 1'b0, freeze_acc = 1'b0;
   logic nv_valid_in = 1'b0, acc_req = 1'b0, tf_wr, cmd_done, nv_wr, acc_abort, acc_ok;
   logic [47:0] native_cap = CAP, nv_limit_in = 48'h0, acc_lba = 48'h0;
   mlx_tf_t tf;
   mlx_rb_t rb;
   logic [7:0] status_flags, error_report;
   logic [47:0] nv_wr_lba, max_limit, lim; // lim is the expected limit
   logic [63:0] id_w100_103;
   logic [31:0] id_w60_61, id60; // id60 valid once idk is set
   logic prev27, locked, frozen, nvdone, idk; // expected device state
   int err_count = 0, cmp_count = 0;

   always #5 core_clk = ~core_clk;

   mlx_host host (.core_clk(core_clk), .tf_wr(tf_wr), .tf(tf));
   mlx_max_lba_ext dut (.core_clk(core_clk), .rst_b(rst_b), .tf_wr(tf_wr), .tf(tf), .hob(hob),
      .rb(rb), .status_flags(status_flags), .error_report(error_report), .cmd_done(cmd_done),
      .feature_on(feature_on), .native_cap(native_cap), .hpa28_set(hpa28_set),
      .offset_mode(offset_mode), .lock_acc(lock_acc), .unlock_acc(unlock_acc),
      .freeze_acc(freeze_acc), .nv_valid_in(nv_valid_in), .nv_limit_in(nv_limit_in),
      .nv_wr(nv_wr), .nv_wr_lba(nv_wr_lba), .id_w100_103(id_w100_103), .id_w60_61(id_w60_61),
      .max_limit(max_limit), .acc_req(acc_req), .acc_lba(acc_lba), .acc_abort(acc_abort),
      .acc_ok(acc_ok));

   // compare and count
   task automatic chk(input logic [63:0] a, input logic [63:0] e);
      cmp_count++;
      if (a !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
      end
   endtask
   // single exit point of the run
   task automatic stop_test();
      $display("errors=%0d compares=%0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // settle past the edge so registered outputs are read stable
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // power-on style reset, optionally with a persisted limit in the store
   task automatic do_reset(input logic nvv, input logic [47:0] nvl);
      nv_valid_in <= nvv;
      nv_limit_in <= nvl;
      rst_b <= 1'b0;
      tick(10);
      chk(status_flags, MLX_STATUS_RST);
      rst_b <= 1'b1;
      for (int i = 0; i < 10 && status_flags !== MLX_STATUS_OK; i++) tick(1);
      if (status_flags !== MLX_STATUS_OK) begin
         err_count++;
         stop_test();
      end
      lim = nvv ? nvl : CAP;
      {prev27, locked, frozen, nvdone} = 4'b0000;
      // words 61:60 come up at the full 28-bit value after reset
      id60 = 32'h0fff_ffff;
      idk = 1'b1;
      chk(max_limit, lim);
   endtask
   // one command, then status, limit and identify words against the model
   task automatic cmd(input logic [7:0] c, input logic [47:0] l, input logic nv);
      logic abt;
      logic take;
      host.send(c, l, nv);
      abt = (c == SET) && (!feature_on || hpa28_set || !prev27 || l > CAP || locked
         || frozen || (nv && (offset_mode || nvdone)));
      take = (c == SET) && !abt;
      for (int i = 0; i < 8 && cmd_done !== 1'b1; i++) tick(1);
      if (cmd_done !== 1'b1) begin
         err_count++;
         stop_test();
      end
      chk(status_flags, abt ? MLX_STATUS_FAIL : MLX_STATUS_OK);
      chk(error_report, abt ? MLX_ERROR_ABT : MLX_ERROR_RST);
      chk(nv_wr, take && nv);
      if (take) begin
         lim = l;
         nvdone |= nv;
         if (nv) chk(nv_wr_lba, l);
         if (l <= MLX_LBA28_MAX) begin
            id60 = l[31:0];
            idk = 1'b1;
         end
      end
      prev27 = (c == RDN);
      chk(max_limit, lim);
      chk(id_w100_103, {16'h0000, lim});
      if (idk) chk(id_w60_61, id60);
   endtask
   // the legal pair: native read directly before the set
   task automatic set(input logic [47:0] l, input logic nv);
      cmd(RDN, 48'h0, 1'b0);
      cmd(SET, l, nv);
   endtask
   // both readback pages
   task automatic rdback();
      for (int h = 0; h < 2; h++) begin
         @(posedge core_clk);
         hob <= h[0];
         tick(2);
         chk(rb, h ? {lim[31:24], lim[39:32], lim[47:40]} : {lim[7:0], lim[15:8], lim[23:16]});
      end
   endtask
   // media access check against the expected limit
   task automatic acc(input logic [47:0] l);
      @(posedge core_clk);
      acc_req <= 1'b1;
      acc_lba <= l;
      @(posedge core_clk);
      acc_req <= 1'b0;
      acc_lba <= ~l;
      #1;
      chk({acc_abort, acc_ok}, (l > lim) ? 2'b10 : 2'b01);
   endtask
   // pulse one subcommand event: 0 lock, 1 unlock, 2 freeze
   task automatic ev(input int k);
      @(posedge core_clk);
      lock_acc <= (k == 0);
      unlock_acc <= (k == 1);
      freeze_acc <= (k == 2);
      @(posedge core_clk);
      {lock_acc, unlock_acc, freeze_acc} <= 3'b000;
      if (k < 2) locked = (k == 0);
      if (k == 2) {frozen, locked} = 2'b10;
   endtask

   initial begin
      logic [47:0] l;
      void'($urandom(32'hc96c121a));
      do_reset(1'b0, 48'h0);
      cmd(SET, 48'h100, 1'b0);
      set(MLX_LBA28_MAX, 1'b0);
      rdback();
      set(MLX_LBA28_MAX + 48'h1, 1'b0);
      rdback();
      acc(lim);
      acc(lim + 48'h1);
      set(CAP + 48'h1, 1'b0);
      set(CAP, 1'b0);
      cmd(RDN, 48'h0, 1'b0);
      cmd(8'hc6, 48'h0, 1'b0);
      cmd(SET, 48'h200, 1'b0);
      // unsupported, then an old 28-bit protected area
      for (int k = 0; k < 2; k++) begin
         feature_on <= (k != 0);
         hpa28_set <= (k == 1);
         set(48'h5000, 1'b0);
      end
      feature_on <= 1'b1;
      hpa28_set <= 1'b0;
      offset_mode <= 1'b1;
      set(48'h0000_1234_5678, 1'b1);
      offset_mode <= 1'b0;
      set(48'h0000_1234_5678, 1'b1);
      set(48'h0000_0000_0900, 1'b1);
      set(48'h300, 1'b0);
      ev(0);
      set(48'h400, 1'b0);
      ev(1);
      set(48'h500, 1'b0);
      ev(0);
      ev(2);
      set(48'h600, 1'b0);
      ev(1);
      set(48'h700, 1'b0);
      do_reset(1'b1, 48'h0000_2222_3333);
      set(48'h0000_0000_0777, 1'b1);
      // random limits, some beyond capacity, each probed by an access
      for (int i = 0; i < 20; i++) begin
         l = {16'h0000, $urandom()} << $urandom_range(12, 0);
         set(l, 1'b0);
         rdback();
         // probe one address picked at random from just below, at or just above the expected limit
         acc(lim - 48'h1 + 48'($urandom_range(2, 0)));
      end
      stop_test();
   end
endmodule // tb_max_lba_limit_ext_command
